// ### rtl/slp_latch_ctrl.sv
// Purpose: Serial latch bank and power-down sequencing for a synthesizer
// Assumes: Serial clock, data, load strobe, chip enable and the reference
//          divider output all arrive asynchronously and are oversampled
// Notes:   Serial clock must be slower than a third of clk_sys_in
`timescale 1ns/1ps
module slp_latch_ctrl
  import slp_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        serial_clk_in,
  input  wire logic        serial_data_in,
  input  wire logic        load_strobe_in,
  input  wire logic        chip_enable_in,
  input  wire logic        ref_div_out_in,
  output logic [23:0]      control_word_out,
  output logic [23:0]      feedback_word_out,
  output logic [23:0]      reference_word_out,
  output logic [1:0]       prescaler_sel_out,
  output logic [12:0]      main_divider_out,
  output logic [4:0]       swallow_count_out,
  output logic [13:0]      ref_ratio_out,
  output logic             pump_gain_out,
  output logic             powered_down_out,
  output logic             counters_load_out,
  output logic             pump_hiz_out,
  output logic             lock_clear_out,
  output logic             bias_off_out,
  output logic             rf_hiz_out,
  output logic             ref_buf_off_out,
  output logic             band_select_start_out
);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLP_ST_INIT   = 2'b00,  // Waiting for the first control write
    SLP_ST_ACTIVE = 2'b01,
    SLP_ST_ARMED  = 2'b10,  // Synchronous power-down counting edges
    SLP_ST_DOWN   = 2'b11
  } slp_state_t;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       sclk_s;
  logic       sdata_s;
  logic       load_s;
  logic       ce_s;
  logic       refo_s;

  slp_pin_sync #(
    .WIDTH        (5)
  ) u_sync (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .async_in     ({serial_clk_in, serial_data_in, load_strobe_in,
                    chip_enable_in, ref_div_out_in}),
    .reset_val_in (5'h00),
    .sync_out     (pins_s)
  );

  assign {sclk_s, sdata_s, load_s, ce_s, refo_s} = pins_s;

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  logic sclk_last_q;
  logic load_last_q;
  logic refo_last_q;
  logic sclk_rise;
  logic load_rise;
  logic refo_rise;

  // History flops for rising-edge detection
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sclk_last_q <= 1'b0;
      load_last_q <= 1'b0;
      refo_last_q <= 1'b0;
    end else begin
      sclk_last_q <= sclk_s;
      load_last_q <= load_s;
      refo_last_q <= refo_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_last_q;
  assign load_rise = load_s & ~load_last_q;
  assign refo_rise = refo_s & ~refo_last_q;

  // ----------------------------------------------------------------
  // Input shift register
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] shift_q;

  // Never gated by power state, so words land even while powered down
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      shift_q <= WORD_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], sdata_s};
    end
  end

  // ----------------------------------------------------------------
  // Latch bank
  // ----------------------------------------------------------------
  logic [1:0] route;
  logic       wr_ctrl;
  logic       wr_ref;
  logic       wr_fb;

  assign route   = shift_q[1:0];
  assign wr_ctrl = load_rise && (route == ROUTE_CTRL);
  assign wr_ref  = load_rise && (route == ROUTE_REF);
  assign wr_fb   = load_rise && (route == ROUTE_FB);
  // Test routing is dropped: that latch is not implemented here

  // Latches only change on a write; power-down never touches them
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      control_word_out   <= WORD_RESET;
      feedback_word_out  <= WORD_RESET;
      reference_word_out <= WORD_RESET;
    end else begin
      if (wr_ctrl) begin
        control_word_out <= shift_q;
      end
      if (wr_fb) begin
        feedback_word_out <= shift_q;
      end
      if (wr_ref) begin
        reference_word_out <= shift_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  // Fields are picked from the incoming word so they track each write
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prescaler_sel_out <= 2'h0;
      main_divider_out  <= 13'h0000;
      swallow_count_out <= 5'h00;
      ref_ratio_out     <= 14'h0000;
    end else begin
      if (wr_ctrl) begin
        prescaler_sel_out <= shift_q[CTL_PRESCALE_LSB +: 2];
      end
      if (wr_fb) begin
        main_divider_out  <= shift_q[FB_MAIN_LSB +: FB_MAIN_W];
        swallow_count_out <= shift_q[FB_SWALLOW_LSB +: FB_SWALLOW_W];
      end
      if (wr_ref) begin
        ref_ratio_out <= shift_q[REF_RATIO_LSB +: REF_RATIO_W];
      end
    end
  end

  // Pump gain follows whichever latch wrote it last
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pump_gain_out <= 1'b0;
    end else if (wr_ctrl) begin
      pump_gain_out <= shift_q[CTL_GAIN_BIT];
    end else if (wr_fb) begin
      pump_gain_out <= shift_q[FB_GAIN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Power sequencing
  // ----------------------------------------------------------------
  slp_state_t state_q;
  slp_state_t state_d;
  logic [1:0] edge_cnt_q;
  logic       new_mode;
  logic       new_trig;

  assign new_mode = shift_q[CTL_PD_MODE_BIT];
  assign new_trig = shift_q[CTL_PD_TRIG_BIT];

  // Next power state; a fresh control write always takes priority
  always_comb begin
    state_d = state_q;
    case (state_q)
      SLP_ST_INIT: begin
        if (wr_ctrl) begin
          state_d = SLP_ST_ACTIVE;
        end
      end
      SLP_ST_ACTIVE, SLP_ST_ARMED, SLP_ST_DOWN: begin
        if (state_q == SLP_ST_ARMED && refo_rise &&
            edge_cnt_q == 2'(SYNC_PD_EDGES - 1)) begin
          state_d = SLP_ST_DOWN;
        end
        if (wr_ctrl) begin
          if (new_trig && !new_mode) begin
            state_d = SLP_ST_DOWN;
          end else if (new_trig && new_mode) begin
            state_d = (state_q == SLP_ST_DOWN) ? SLP_ST_DOWN : SLP_ST_ARMED;
          end else begin
            state_d = SLP_ST_ACTIVE;
          end
        end
      end
      default: state_d = SLP_ST_INIT;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_q <= SLP_ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts reference-divider edges after the strobe that armed the mode
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      edge_cnt_q <= 2'h0;
    end else if (wr_ctrl || state_q != SLP_ST_ARMED) begin
      edge_cnt_q <= 2'h0;
    end else if (refo_rise) begin
      edge_cnt_q <= edge_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Power-down side effects
  // ----------------------------------------------------------------
  logic down_d;
  logic ctrl_tri;

  // Chip enable overrides both programmed modes
  assign down_d   = !ce_s || (state_d == SLP_ST_INIT) || (state_d == SLP_ST_DOWN);
  assign ctrl_tri = wr_ctrl ? shift_q[CTL_TRISTATE_BIT]
                            : control_word_out[CTL_TRISTATE_BIT];

  // All effects registered together so they switch in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      powered_down_out  <= 1'b1;
      counters_load_out <= 1'b1;
      pump_hiz_out      <= 1'b1;
      lock_clear_out    <= 1'b1;
      bias_off_out      <= 1'b1;
      rf_hiz_out        <= 1'b1;
      ref_buf_off_out   <= 1'b1;
    end else begin
      powered_down_out  <= down_d;
      counters_load_out <= down_d;
      pump_hiz_out      <= down_d || ctrl_tri;
      lock_clear_out    <= down_d;
      bias_off_out      <= down_d;
      rf_hiz_out        <= down_d;
      ref_buf_off_out   <= down_d;
    end
  end

  // ----------------------------------------------------------------
  // Band selection start
  // ----------------------------------------------------------------
  // A feedback write picks a new band; power-up without one keeps the old
  // band, so nothing restarts here when leaving power-down
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      band_select_start_out <= 1'b0;
    end else begin
      band_select_start_out <= wr_fb;
    end
  end

endmodule // slp_latch_ctrl

// ### rtl/slp_pkg.sv
// Purpose: Shared constants for the synthesizer serial latch and power-down block
// Assumes: 24-bit words, routing in the two lowest bits
// Notes:   Field positions are low bit indices inside the 24-bit word
package slp_pkg;

  // ----------------------------------------------------------------
  // Word and routing
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W      = 24;
  localparam logic [1:0]  ROUTE_CTRL  = 2'h0;
  localparam logic [1:0]  ROUTE_REF   = 2'h1;
  localparam logic [1:0]  ROUTE_FB    = 2'h2;
  localparam logic [1:0]  ROUTE_TEST  = 2'h3;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_PRESCALE_LSB  = 22;
  localparam int unsigned CTL_PD_MODE_BIT   = 21;
  localparam int unsigned CTL_PD_TRIG_BIT   = 20;
  localparam int unsigned CTL_PUMP2_LSB     = 17;
  localparam int unsigned CTL_PUMP1_LSB     = 14;
  localparam int unsigned CTL_OUTPWR_LSB    = 12;
  localparam int unsigned CTL_MUTE_BIT      = 11;
  localparam int unsigned CTL_GAIN_BIT      = 10;
  localparam int unsigned CTL_TRISTATE_BIT  = 9;
  localparam int unsigned CTL_POLARITY_BIT  = 8;
  localparam int unsigned CTL_MONITOR_LSB   = 5;
  localparam int unsigned CTL_CLEAR_BIT     = 4;
  localparam int unsigned CTL_CORE_PWR_LSB  = 2;

  // ----------------------------------------------------------------
  // Feedback-divider word fields
  // ----------------------------------------------------------------
  localparam int unsigned FB_HALF_PRESC_BIT = 23;
  localparam int unsigned FB_HALVING_BIT    = 22;
  localparam int unsigned FB_GAIN_BIT       = 21;
  localparam int unsigned FB_MAIN_LSB       = 8;
  localparam int unsigned FB_MAIN_W         = 13;
  localparam int unsigned FB_SWALLOW_LSB    = 2;
  localparam int unsigned FB_SWALLOW_W      = 5;

  // ----------------------------------------------------------------
  // Reference-divider word fields
  // ----------------------------------------------------------------
  localparam int unsigned REF_RATIO_LSB     = 2;
  localparam int unsigned REF_RATIO_W       = 14;
  localparam int unsigned REF_BACKLASH_LSB  = 16;
  localparam int unsigned REF_PRECISION_BIT = 18;
  localparam int unsigned REF_TEST_BIT      = 19;
  localparam int unsigned REF_BANDCLK_LSB   = 20;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [23:0] WORD_RESET        = 24'h000000;
  localparam int unsigned SYNC_PD_EDGES     = 2;
  localparam int unsigned SYNC_STAGES       = 2;

endpackage : slp_pkg

// ### rtl/slp_pin_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to clk_sys_in
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module slp_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Reset value arrives on the reset_val_in port and loads both flop stages
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_q   <= reset_val_in;
      sync_out <= reset_val_in;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // slp_pin_sync

// ### sim/slp_latch_checker.sv
// Purpose: Port-level checks on the serial latch and power-down block
// Assumes: Latch ports update 3 clocks after a load strobe pin rise
// Notes:   Attached to every slp_latch_ctrl instance by bind
`timescale 1ns/1ps
module slp_latch_checker (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        load_strobe_in,
  input wire logic        chip_enable_in,
  input wire logic [23:0] control_word_out,
  input wire logic [23:0] feedback_word_out,
  input wire logic [23:0] reference_word_out,
  input wire logic [1:0]  prescaler_sel_out,
  input wire logic [12:0] main_divider_out,
  input wire logic [4:0]  swallow_count_out,
  input wire logic [13:0] ref_ratio_out,
  input wire logic        powered_down_out,
  input wire logic        counters_load_out,
  input wire logic        pump_hiz_out,
  input wire logic        lock_clear_out,
  input wire logic        bias_off_out,
  input wire logic        rf_hiz_out,
  input wire logic        ref_buf_off_out,
  input wire logic        band_select_start_out
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Strobe seen high a few clocks ago; window allows for synchroniser skew
  sequence s_load_recent;
    $past(load_strobe_in, 2) || $past(load_strobe_in, 3) || $past(load_strobe_in, 4) ||
    $past(load_strobe_in, 5) || $past(load_strobe_in, 6);
  endsequence
  sequence s_ce_drop;
    $fell(chip_enable_in);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_LOAD_ONLY: assert property (($changed(control_word_out) ||
    $changed(feedback_word_out) || $changed(reference_word_out)) |-> s_load_recent)
    else $error("latch changed without a load strobe");
  AST_PRESCALER: assert property (prescaler_sel_out == control_word_out[23:22])
    else $error("prescaler field mismatch");
  AST_FB_FIELDS: assert property (main_divider_out == feedback_word_out[20:8] &&
    swallow_count_out == feedback_word_out[6:2]) else $error("feedback fields mismatch");
  AST_REF_RATIO: assert property (ref_ratio_out == reference_word_out[15:2])
    else $error("reference ratio mismatch");
  AST_CE_DOWN: assert property (s_ce_drop |-> ##[1:4] powered_down_out)
    else $error("chip enable low did not power down");
  AST_COUNTERS: assert property (counters_load_out == powered_down_out)
    else $error("counter load state mismatch");
  AST_PUMP_HIZ: assert property (powered_down_out |-> pump_hiz_out)
    else $error("pump not tri-stated while down");
  AST_LOCK_CLEAR: assert property (lock_clear_out == powered_down_out)
    else $error("lock clear mismatch");
  AST_DOWN_OUTPUTS: assert property ({bias_off_out, rf_hiz_out, ref_buf_off_out} ==
    {3{powered_down_out}}) else $error("power-down outputs mismatch");
  AST_BAND_PULSE: assert property (band_select_start_out |=> !band_select_start_out)
    else $error("band start longer than one cycle");
  AST_BAND_ON_FB: assert property ($changed(feedback_word_out) |-> band_select_start_out)
    else $error("feedback write without band start");
endmodule // slp_latch_checker

bind slp_latch_ctrl slp_latch_checker u_checker (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .load_strobe_in(load_strobe_in),
  .chip_enable_in(chip_enable_in), .control_word_out(control_word_out),
  .feedback_word_out(feedback_word_out), .reference_word_out(reference_word_out),
  .prescaler_sel_out(prescaler_sel_out), .main_divider_out(main_divider_out),
  .swallow_count_out(swallow_count_out), .ref_ratio_out(ref_ratio_out),
  .powered_down_out(powered_down_out), .counters_load_out(counters_load_out),
  .pump_hiz_out(pump_hiz_out), .lock_clear_out(lock_clear_out),
  .bias_off_out(bias_off_out), .rf_hiz_out(rf_hiz_out),
  .ref_buf_off_out(ref_buf_off_out), .band_select_start_out(band_select_start_out));

// ### sim/slp_host_model.sv
// Purpose: Host side of the 3-wire programming link
// Assumes: Serial clock high phase lasts 4 system clocks, low phase 5
// Notes:   Serial clock stands low between frames
`timescale 1ns/1ps
module slp_host_model (
  input  wire logic clk_sys_in,
  output logic      serial_clk_out,
  output logic      serial_data_out,
  output logic      load_strobe_out
);
  initial begin
    serial_clk_out  = 1'b0;
    serial_data_out = 1'b0;
    load_strobe_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // Word transfer; caller keeps write order and spacing
  // ----------------------------------------------------------------
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk_sys_in);
      serial_data_out <= word[i];
      repeat (4) @(posedge clk_sys_in);
      serial_clk_out <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      serial_clk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_sys_in);
    load_strobe_out <= 1'b1;
    serial_data_out <= ~word[0]; // Released line must not echo the last bit
    repeat (4) @(posedge clk_sys_in);
    load_strobe_out <= 1'b0;
  endtask
endmodule // slp_host_model

// ### sim/synth_latch_and_powerdown_ctrl_tb.sv
// Purpose: Self-checking bench for the serial latch and power-down block
// Assumes: Random words from seed 89, corner cases written by hand
// Notes:   Expected latch contents kept per route in exp_w
`timescale 1ns/1ps
module synth_latch_and_powerdown_ctrl_tb;
  import slp_pkg::*;
  localparam int SETTLE_CYC = 24000; // 600 us bias settling at 25 ns per clock
  logic        clk_sys_in, rst_n_in, chip_enable_in, ref_div_out_in;
  logic        sclk, sdata, lstb, gain, pd, phiz, rfhiz, band;
  logic [23:0] ctl_w, fb_w, ref_w;
  logic [1:0]  presc, rr;
  logic [12:0] main_d;
  logic [4:0]  swal;
  logic [13:0] ratio;
  logic [23:0] exp_w [4];
  logic        exp_pd, exp_gain;
  int          err_total, samples_checked, seed;
  int          band_seen = 0;
  int          exp_band = 0;

  // Counts band-start pulses so a stray restart on wake-up is caught
  always @(posedge clk_sys_in) begin
    if (band === 1'b1) band_seen <= band_seen + 1;
  end

  // ----------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  slp_host_model u_host (.clk_sys_in(clk_sys_in), .serial_clk_out(sclk),
    .serial_data_out(sdata), .load_strobe_out(lstb));
  slp_latch_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .serial_clk_in(sclk), .serial_data_in(sdata), .load_strobe_in(lstb),
    .chip_enable_in(chip_enable_in), .ref_div_out_in(ref_div_out_in),
    .control_word_out(ctl_w), .feedback_word_out(fb_w), .reference_word_out(ref_w),
    .prescaler_sel_out(presc), .main_divider_out(main_d), .swallow_count_out(swal),
    .ref_ratio_out(ratio), .pump_gain_out(gain), .powered_down_out(pd),
    .counters_load_out(), .pump_hiz_out(phiz), .lock_clear_out(), .bias_off_out(),
    .rf_hiz_out(rfhiz), .ref_buf_off_out(), .band_select_start_out(band));

  // ----------------------------------------------------------------
  // Compare, expectation and stimulus helpers
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({23'h0, got}, {23'h0, exp});
  endtask
  // Random word with reserved bits held legal for its route
  function automatic logic [23:0] rnd_word(input logic [1:0] route, input logic [1:0] pdb);
    logic [23:0] w;
    w = 24'($random(seed));
    w[1:0] = route;
    if (route == ROUTE_CTRL) w[21:20] = pdb;
    if (route == ROUTE_FB) w[7] = 1'b0;
    if (route == ROUTE_REF) w[23:19] = {w[21:20], 3'h0} >> 2;
    // Divider ratios kept inside their legal ranges
    if (route == ROUTE_FB && w[20:8] < 13'h0003) w[20:8] = 13'h0003;
    if (route == ROUTE_REF && w[15:2] == 14'h0000) w[2] = 1'b1;
    return w;
  endfunction
  task automatic put(input logic [23:0] w);
    u_host.send(w);
    if (w[1:0] != ROUTE_TEST) exp_w[w[1:0]] = w;
    if (w[1:0] == ROUTE_CTRL) exp_gain = w[10];
    if (w[1:0] == ROUTE_FB) exp_gain = w[21];
    if (w[1:0] == ROUTE_FB) exp_band++;
    if (w[1:0] == ROUTE_CTRL && w[21:20] != 2'h3) exp_pd = (w[21:20] == 2'h1);
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic check_latches();
    #1;
    chk_word(ctl_w, exp_w[0]);
    chk_word(fb_w, exp_w[2]);
    chk_word(ref_w, exp_w[1]);
    chk_word({22'h0, presc}, {22'h0, exp_w[0][23:22]});
    chk_word({11'h0, main_d}, {11'h0, exp_w[2][20:8]});
    chk_word({19'h0, swal}, {19'h0, exp_w[2][6:2]});
    chk_word({10'h0, ratio}, {10'h0, exp_w[1][15:2]});
    chk_flag(gain, exp_gain);
    chk_flag(pd, exp_pd);
    chk_flag(phiz, exp_pd | exp_w[0][9]);
    chk_flag(rfhiz, exp_pd);
    chk_word(24'(band_seen), 24'(exp_band));
  endtask
  task automatic ref_pulse();
    @(posedge clk_sys_in);
    ref_div_out_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    ref_div_out_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic do_reset(input int n);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (n) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    exp_w = '{default: WORD_RESET};
    exp_pd = 1'b1;
    exp_gain = 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 89;
    err_total = 0;
    samples_checked = 0;
    rst_n_in = 1'b0;
    chip_enable_in = 1'b1;
    ref_div_out_in = 1'b0;
    do_reset(19);
    check_latches();
    put(rnd_word(ROUTE_REF, 2'h0));
    put(rnd_word(ROUTE_CTRL, 2'h0));
    repeat (SETTLE_CYC) @(posedge clk_sys_in);
    put(rnd_word(ROUTE_FB, 2'h0));
    check_latches();
    put(rnd_word(ROUTE_TEST, 2'h0));
    check_latches();
    end_test("order");
    for (int i = 0; i < 14; i++) begin
      rr = 2'($random(seed));
      if (rr == ROUTE_FB && exp_pd) rr = ROUTE_REF;
      put(rnd_word(rr, {1'b0, 1'($random(seed))}));
      check_latches();
    end
    end_test("random");
    put(rnd_word(ROUTE_CTRL, 2'h0));
    put(rnd_word(ROUTE_CTRL, 2'h1));
    check_latches();
    put(rnd_word(ROUTE_REF, 2'h0));
    check_latches();
    put(rnd_word(ROUTE_CTRL, 2'h0));
    check_latches();
    end_test("async");
    put(rnd_word(ROUTE_CTRL, 2'h3));
    check_latches();
    ref_pulse();
    check_latches();
    ref_pulse();
    exp_pd = 1'b1;
    check_latches();
    put(rnd_word(ROUTE_CTRL, 2'h2));
    check_latches();
    end_test("sync");
    @(posedge clk_sys_in);
    chip_enable_in <= 1'b0;
    exp_pd = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    check_latches();
    @(posedge clk_sys_in);
    chip_enable_in <= 1'b1;
    exp_pd = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    check_latches();
    end_test("chip_enable");
    do_reset(3);
    check_latches();
    end_test("rereset");
    complete_run();
  end

  // Hang guard sized well above the expected run of about 29600 clocks
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    err_total++;
    complete_run();
  end
endmodule // synth_latch_and_powerdown_ctrl_tb
